// *** core/ddr_io_cell.sv ***
`timescale 1ns/1ns
module ddr_io_cell
  import ddr_io_pkg::*;
#(
  parameter int BUF_W = 2
) (
  input wire logic MCLK,
  input wire logic RST,
  // Input clock enables: primary and secondary (falling) sample points
  input wire logic ICLK_PRIMARY_EN,
  input wire logic ICLK_SECONDARY_EN,
  input wire logic CASCADE_EN,
  // Output clock enables
  input wire logic OCLK_PRIMARY_EN,
  input wire logic OCLK_SECONDARY_EN,
  // Fabric output stream, pairs of bits {second, first}
  input wire logic TX_VALID,
  input wire logic [1:0] TX_DATA,
  output logic TX_READY,
  // Fabric input stream
  output logic RX_VALID,
  output logic [1:0] RX_DATA,
  input wire logic RX_READY,
  output logic RX_OVERRUN,
  // Pad
  input wire logic PAD_IN,
  output logic PAD_OUT,
  output logic PAD_OE_N,
  input wire logic DRIVE_EN,
  // Static configuration
  input wire logic CONFIGURING,
  input wire logic PIN_USED,
  input wire logic CONFIG_PULLUP_SELECT_PIN_N,
  input wire logic [1:0] IDLE_PIN_TERMINATION,
  input wire logic PULLUP_EN,
  input wire logic PULLDOWN_EN,
  input wire logic KEEPER_EN,
  input wire logic EDGE_FAST_SEL,
  input wire logic [2:0] DRIVE_SEL,
  input wire logic [2:0] SIGNALLING_STANDARD_SETTING,
  output logic PULLUP_ON,
  output logic PULLDOWN_ON,
  output logic KEEPER_ON,
  output logic KEEP_LEVEL,
  output logic EDGE_RATE,
  output logic [2:0] DRIVE_STRENGTH,
  output logic [2:0] STD_OUT
);

  // Both buffers are built for exactly two entries
  if (BUF_W != BUF_DEPTH) begin : bad_buf_w
    $error("ddr_io_cell: BUF_W must be 2");
  end

  // ---------------- Input DDR ----------------
  logic first_ddr_bit_q, second_ddr_bit_q, slave_bit_q, pair_v_q, pair_hi_q;
  logic [1:0] pair_q;

  assign pair_q = {pair_hi_q, first_ddr_bit_q};

  always_ff @(posedge MCLK) begin
    if (RST) begin
      first_ddr_bit_q <= 1'h0;
    end else if (ICLK_PRIMARY_EN) begin
      first_ddr_bit_q <= PAD_IN;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      second_ddr_bit_q <= 1'h0;
    end else if (ICLK_SECONDARY_EN) begin
      second_ddr_bit_q <= PAD_IN;
    end
  end

  // Slave cell store, retimed to the primary input clock
  always_ff @(posedge MCLK) begin
    if (RST) begin
      slave_bit_q <= 1'h0;
    end else if (ICLK_PRIMARY_EN) begin
      slave_bit_q <= second_ddr_bit_q;
    end
  end

  // Pair presented on primary clock; cascaded second bit or raw one
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pair_hi_q <= 1'h0;
      pair_v_q <= 1'h0;
    end else begin
      pair_v_q <= ICLK_PRIMARY_EN;
      if (ICLK_PRIMARY_EN) begin
        pair_hi_q <= CASCADE_EN ? slave_bit_q : second_ddr_bit_q;
      end
    end
  end

  // Two-entry receive buffer
  logic [1:0] rbuf_q [BUF_DEPTH];
  logic [1:0] rcnt_q;
  logic rwp_q, rrp_q;
  logic rpush, rpop;

  assign rpop = RX_VALID && RX_READY;
  assign rpush = pair_v_q && (rcnt_q != 2'h2 || rpop);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rcnt_q <= 2'h0;
      rwp_q <= 1'h0;
      rrp_q <= 1'h0;
    end else begin
      if (rpush) begin
        rbuf_q[rwp_q] <= pair_q;
        rwp_q <= ~rwp_q;
      end
      if (rpop) begin
        rrp_q <= ~rrp_q;
      end
      rcnt_q <= rcnt_q + {1'h0, rpush} - {1'h0, rpop};
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      RX_VALID <= 1'h0;
      RX_DATA <= 2'h0;
    end else begin
      logic [1:0] n;
      n = rcnt_q + {1'h0, rpush} - {1'h0, rpop};
      RX_VALID <= (n != 2'h0);
      // Head shown only from written entries, never from an empty slot
      if (rpush && (rcnt_q == 2'h0 || (rcnt_q == 2'h1 && rpop))) begin
        RX_DATA <= pair_q;
      end else if (rpop && rcnt_q == 2'h2) begin
        RX_DATA <= rbuf_q[~rrp_q];
      end
    end
  end

  // Overrun is sticky until reset; a pair lost when buffer is full
  always_ff @(posedge MCLK) begin
    if (RST) begin
      RX_OVERRUN <= 1'h0;
    end else if (pair_v_q && !rpush) begin
      RX_OVERRUN <= 1'h1;
    end
  end

  // ---------------- Output DDR ----------------
  // Two-entry transmit buffer; drained one pair per primary output clock
  logic [1:0] tbuf_q [BUF_DEPTH];
  logic [1:0] tcnt_q;
  logic twp_q, trp_q;
  logic tpush, tpop;

  assign tpop = OCLK_PRIMARY_EN && (tcnt_q != 2'h0);
  assign tpush = TX_VALID && TX_READY;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      tcnt_q <= 2'h0;
      twp_q <= 1'h0;
      trp_q <= 1'h0;
      TX_READY <= 1'h0;
    end else begin
      logic [1:0] n;
      n = tcnt_q + {1'h0, tpush} - {1'h0, tpop};
      if (tpush) begin
        tbuf_q[twp_q] <= TX_DATA;
        twp_q <= ~twp_q;
      end
      if (tpop) begin
        trp_q <= ~trp_q;
      end
      tcnt_q <= n;
      TX_READY <= (n != 2'h2);
    end
  end

  // First bit on primary clock; second bit staged into the secondary domain
  logic d1_q, d2_stage_q, d2_q;
  phase_t phase_q;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      d1_q <= 1'h0;
      d2_stage_q <= 1'h0;
    end else if (OCLK_PRIMARY_EN) begin
      d1_q <= tpop ? tbuf_q[trp_q][0] : d1_q;
      d2_stage_q <= tpop ? tbuf_q[trp_q][1] : d2_stage_q;
    end
  end

  // Plain two-clock register, no alignment select
  always_ff @(posedge MCLK) begin
    if (RST) begin
      d2_q <= 1'h0;
    end else if (OCLK_SECONDARY_EN) begin
      d2_q <= d2_stage_q;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      phase_q <= PH_FIRST;
    end else if (OCLK_PRIMARY_EN) begin
      phase_q <= PH_FIRST;
    end else if (OCLK_SECONDARY_EN) begin
      phase_q <= PH_SECOND;
    end
  end

  // DDR mux onto the pad
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PAD_OUT <= 1'h0;
    end else begin
      case (phase_q)
        PH_FIRST: PAD_OUT <= d1_q;
        PH_SECOND: PAD_OUT <= d2_q;
        default: PAD_OUT <= 1'h0;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      PAD_OE_N <= 1'h1;
    end else begin
      PAD_OE_N <= ~DRIVE_EN;
    end
  end

  // ---------------- Termination and keeper ----------------
  logic cfg_pull_up, idle_pull_up, idle_pull_dn;

  assign cfg_pull_up = CONFIGURING && !PIN_USED && !CONFIG_PULLUP_SELECT_PIN_N;
  assign idle_pull_up = !CONFIGURING && !PIN_USED &&
    (IDLE_PIN_TERMINATION == TERM_PULLUP);
  assign idle_pull_dn = !CONFIGURING && !PIN_USED &&
    (IDLE_PIN_TERMINATION != TERM_PULLUP) &&
    (IDLE_PIN_TERMINATION != TERM_FLOAT);

  // Settings sampled only while configuring, frozen afterwards
  logic pu_cfg_q, pd_cfg_q, keep_cfg_q;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      pu_cfg_q <= 1'h0;
      pd_cfg_q <= 1'h0;
      keep_cfg_q <= RST_KEEP;
      EDGE_RATE <= EDGE_SLOW;
      DRIVE_STRENGTH <= DRIVE_12MA;
      STD_OUT <= STD_CMOS25;
    end else if (CONFIGURING) begin
      pu_cfg_q <= PULLUP_EN;
      pd_cfg_q <= PULLDOWN_EN && !PULLUP_EN;
      keep_cfg_q <= KEEPER_EN;
      EDGE_RATE <= EDGE_FAST_SEL;
      DRIVE_STRENGTH <= (DRIVE_SEL > DRIVE_MAX_CODE) ? DRIVE_12MA : DRIVE_SEL;
      STD_OUT <= SIGNALLING_STANDARD_SETTING;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      PULLUP_ON <= 1'h0;
      PULLDOWN_ON <= 1'h0;
      KEEPER_ON <= 1'h0;
    end else begin
      PULLUP_ON <= cfg_pull_up || idle_pull_up || (PIN_USED && pu_cfg_q);
      PULLDOWN_ON <= !cfg_pull_up && (idle_pull_dn || (PIN_USED && pd_cfg_q));
      KEEPER_ON <= keep_cfg_q && PIN_USED && !pu_cfg_q && !pd_cfg_q;
    end
  end

  // Level on the pad: PAD_OUT while driven, PAD_IN otherwise
  always_ff @(posedge MCLK) begin
    if (RST) begin
      KEEP_LEVEL <= 1'h0;
    end else if (!PAD_OE_N) begin
      KEEP_LEVEL <= PAD_OUT;
    end else begin
      KEEP_LEVEL <= PAD_IN;
    end
  end

endmodule

// *** core/ddr_io_pkg.sv ***
package ddr_io_pkg;
  // Termination choices for an idle pin
  typedef enum logic [1:0] {
    TERM_PULLDOWN = 2'h0,
    TERM_PULLUP = 2'h1,
    TERM_FLOAT = 2'h2
  } term_t;
  // Edge rate
  localparam logic EDGE_SLOW = 1'h0;
  localparam logic EDGE_FAST = 1'h1;
  // Drive code: 0..5 stand for 2,4,6,8,12,16 mA
  localparam logic [2:0] DRIVE_12MA = 3'h4;
  localparam logic [2:0] DRIVE_MAX_CODE = 3'h5;
  // Signalling standard code, default is 2.5 V CMOS
  localparam logic [2:0] STD_CMOS25 = 3'h2;
  localparam logic [1:0] RST_TERM = 2'h0;
  localparam logic RST_KEEP = 1'h0;
  // Output phase sequencer: one-hot
  typedef enum logic [1:0] {
    PH_FIRST = 2'h1,
    PH_SECOND = 2'h2
  } phase_t;
  localparam int BUF_DEPTH = 2;
endpackage

// *** dv/ddr_io_cell_checker.sv ***
`timescale 1ns/1ns
module ddr_io_cell_checker
  import ddr_io_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CONFIGURING,
  input wire logic PIN_USED,
  input wire logic CONFIG_PULLUP_SELECT_PIN_N,
  input wire logic EDGE_FAST_SEL,
  input wire logic [2:0] DRIVE_SEL,
  input wire logic [2:0] SIGNALLING_STANDARD_SETTING,
  input wire logic DRIVE_EN,
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic [1:0] RX_DATA,
  input wire logic RX_OVERRUN,
  input wire logic PAD_OE_N,
  input wire logic PULLUP_ON,
  input wire logic PULLDOWN_ON,
  input wire logic KEEPER_ON,
  input wire logic EDGE_RATE,
  input wire logic [2:0] DRIVE_STRENGTH,
  input wire logic [2:0] STD_OUT
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  drive_map_a: assert property (CONFIGURING |=> DRIVE_STRENGTH == (
    ($past(DRIVE_SEL) > DRIVE_MAX_CODE) ? DRIVE_12MA : $past(DRIVE_SEL)))
    else $error("drive code not applied");
  edge_std_a: assert property (CONFIGURING |=> EDGE_RATE == $past(EDGE_FAST_SEL)
    && STD_OUT == $past(SIGNALLING_STANDARD_SETTING)) else $error("edge or standard wrong");
  frozen_cfg_a: assert property (!CONFIGURING && !$past(CONFIGURING) && !$past(RST)
    |-> $stable(EDGE_RATE) && $stable(DRIVE_STRENGTH)) else $error("setting moved");
  pull_wins_a: assert property ((PULLUP_ON || PULLDOWN_ON) |-> !KEEPER_ON)
    else $error("keeper on with pull");
  cfg_pullup_a: assert property (CONFIGURING && !PIN_USED && !CONFIG_PULLUP_SELECT_PIN_N
    |=> PULLUP_ON && !PULLDOWN_ON) else $error("unused pin not pulled up");
  rx_hold_a: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
    else $error("input pair lost while stalled");
  overrun_keep_a: assert property (RX_OVERRUN |=> RX_OVERRUN)
    else $error("overrun flag dropped");
  pad_drive_a: assert property ($rose(DRIVE_EN) |-> ##[1:2] !PAD_OE_N)
    else $error("pad not driven");
  cover property (RX_OVERRUN);
  cover property (KEEPER_ON);
  cover property (RX_VALID && RX_READY);
endmodule

// *** dv/pad_partner.sv ***
`timescale 1ns/1ns
module pad_partner (
  input wire logic mclk,
  input wire logic pad_out,
  input wire logic pad_oe_n,
  input wire logic ext_en,
  input wire logic ext_bit,
  output logic pad_in
);
  logic last_q = 1'b0;
  // Undriven trace shows a level that flips every cycle
  assign pad_in = !pad_oe_n ? pad_out : (ext_en ? ext_bit : ~last_q);
  always_ff @(posedge mclk) begin
    last_q <= pad_in;
  end
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ns
module testbench
  import ddr_io_pkg::*;
;
  logic MCLK = 0, RST = 1, ICLK_PRIMARY_EN = 0, ICLK_SECONDARY_EN = 0, CASCADE_EN = 0;
  logic OCLK_PRIMARY_EN = 0, OCLK_SECONDARY_EN = 0, TX_VALID = 0, RX_READY = 0;
  logic DRIVE_EN = 0, CONFIGURING = 0, PIN_USED = 1, CONFIG_PULLUP_SELECT_PIN_N = 1;
  logic PULLUP_EN = 0, PULLDOWN_EN = 0, KEEPER_EN = 0, EDGE_FAST_SEL = 0;
  logic ext_en = 0, ext_bit = 0;
  logic [1:0] TX_DATA = 2'h0, IDLE_PIN_TERMINATION = 2'h0;
  logic [2:0] DRIVE_SEL = 3'h0, SIGNALLING_STANDARD_SETTING = 3'h0;
  logic TX_READY, RX_VALID, RX_OVERRUN, PAD_IN, PAD_OUT, PAD_OE_N, PULLUP_ON;
  logic PULLDOWN_ON, KEEPER_ON, KEEP_LEVEL, EDGE_RATE;
  logic [1:0] RX_DATA;
  logic [2:0] DRIVE_STRENGTH, STD_OUT;
  int mismatches = 0, num_checks = 0, cycles = 0;
  ddr_io_cell ddr_io_cell_inst (.*);
  pad_partner pad_partner_inst (.mclk(MCLK), .pad_out(PAD_OUT), .pad_oe_n(PAD_OE_N),
    .ext_en(ext_en), .ext_bit(ext_bit), .pad_in(PAD_IN));
  initial begin
    forever #50 MCLK = ~MCLK;
  end
  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  `define CHK(g, e) cmp(8'(g), 8'(e))
  task automatic tick(input int n = 1);
    repeat (n) @(posedge MCLK);
    #10;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick();
    s = 0;
  endtask
  // Fabric hands {second, first}; held until accepted
  task automatic send(input logic [1:0] d);
    TX_DATA = d;
    TX_VALID = 1;
    while (TX_READY !== 1'b1) tick();
    tick();
    TX_VALID = 0;
  endtask
  task automatic out_pair(input logic [1:0] d);
    pulse(OCLK_PRIMARY_EN);
    tick(2);
    `CHK(PAD_OUT, d[0]);
    pulse(OCLK_SECONDARY_EN);
    tick(2);
    `CHK(PAD_OUT, d[1]);
  endtask
  task automatic rx(input logic [1:0] d);
    ext_bit = d[1];
    pulse(ICLK_SECONDARY_EN);
    ext_bit = d[0];
    pulse(ICLK_PRIMARY_EN);
  endtask
  // Fabric side of the input stream handshakes on any MCLK cycle, not only on the primary clock
  task automatic recv(input logic [1:0] e, input bit chk);
    while (RX_VALID !== 1'b1) tick();
    if (chk) `CHK(RX_DATA, e);
    RX_READY = 1;
    tick();
    RX_READY = 0;
  endtask
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    tick(10);
    RST = 0;
    tick(2);
    `CHK({EDGE_RATE, DRIVE_STRENGTH, STD_OUT}, {EDGE_SLOW, DRIVE_12MA, STD_CMOS25});
    CONFIGURING = 1;
    for (int c = 0; c < 8; c++) begin
      DRIVE_SEL = 3'(c);
      tick(2);
      `CHK(DRIVE_STRENGTH, c > 5 ? DRIVE_12MA : 3'(c));
    end
    // Idle termination applies once configuration is over
    CONFIGURING = 0;
    PIN_USED = 0;
    for (int t = 0; t < 4; t++) begin
      IDLE_PIN_TERMINATION = 2'(t);
      tick(2);
      `CHK({PULLUP_ON, PULLDOWN_ON}, t == 1 ? 2'h2 : (t == 2 ? 2'h0 : 2'h1));
    end
    CONFIGURING = 1;
    CONFIG_PULLUP_SELECT_PIN_N = 0;
    tick(2);
    `CHK(PULLUP_ON, 1'b1);
    CONFIG_PULLUP_SELECT_PIN_N = 1;
    PIN_USED = 1;
    KEEPER_EN = 1;
    tick(2);
    `CHK(KEEPER_ON, 1'b1);
    PULLDOWN_EN = 1;
    EDGE_FAST_SEL = 1;
    SIGNALLING_STANDARD_SETTING = 3'h5;
    tick(2);
    `CHK({PULLDOWN_ON, KEEPER_ON, EDGE_RATE, STD_OUT}, 6'h2D);
    CONFIGURING = 0;
    EDGE_FAST_SEL = 0;
    DRIVE_SEL = 3'h1;
    tick(3);
    `CHK({EDGE_RATE, DRIVE_STRENGTH}, {EDGE_FAST, DRIVE_12MA});
    DRIVE_EN = 1;
    tick(3);
    `CHK(PAD_OE_N, 1'b0);
    for (int p = 0; p < 4; p++) begin
      send(2'(p));
      out_pair(2'(p));
    end
    send(2'h1);
    send(2'h2);
    tick();
    `CHK(TX_READY, 1'b0);
    out_pair(2'h1);
    out_pair(2'h2);
    `CHK(KEEP_LEVEL, 1'b1);
    DRIVE_EN = 0;
    ext_en = 1;
    tick(3);
    `CHK(KEEP_LEVEL, 1'b0);
    for (int p = 0; p < 4; p++) begin
      rx(2'(p));
      recv(2'(p), 1);
    end
    CASCADE_EN = 1;
    for (int p = 1; p < 3; p++) begin
      rx(2'(p));
      rx(2'(p));
      recv(2'h0, 0);
      recv(2'(p), 1);
    end
    CASCADE_EN = 0;
    rx(2'h3);
    repeat (4) rx(2'h0);
    tick(3);
    `CHK({RX_OVERRUN, RX_DATA}, 3'h7);
    complete_run();
  end
endmodule
bind ddr_io_cell ddr_io_cell_checker ddr_io_cell_checker_inst (.*);
